// File: logic/uwt_params.svh
`ifndef UWT_PARAMS_SVH
`define UWT_PARAMS_SVH
// Notes on behaviour
// - Writes to the data register go to the transmit holding register only while it is empty and the transmitter idle.
// - Reads of the data register return the buffered receive byte only.
// - A finished byte is buffered while the shifter takes the next frame.
// - Done flags stay set until software clears them.
// - Interrupt request whenever a done flag is set and interrupts are enabled.
// - Baud timing from 8-bit auto-reload counters; receive counter is hidden.
// - Receive counter runs with the timer and uses the same reload byte.
// - A detected start bit forces a reload of the receive counter.
// - Counter overflows are divided by two to give the bit rate.
// - Timer clock: system clock /4, /12, /48, oscillator /8, or timer pin.
// - Control bit 7 selects 8-bit (clear) or 9-bit (set) frames.
// - 8-bit frame: start, eight data bits LSB first, stop into ninth flag.
// - Writing the data register starts a frame; tx done set at stop start.
// - Frames are received only while the receive enable bit is set.
// - 8-bit accept: rx done clear and, if checking, stop bit is one.
// - On a failed accept buffer, ninth flag and rx done stay unchanged.
// - On overrun the first byte is kept and the later frame is lost.
// - 9-bit frame: start, eight data bits, ninth from control, then stop.
// - 9-bit accept: rx done clear and, if filtering, ninth bit is one.

// ---------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------
`define UWT_ADDR_CTRL 5'h00
`define UWT_ADDR_DATA 5'h04
`define UWT_ADDR_CFG 5'h08
`define UWT_ADDR_RELOAD 5'h0c
`define UWT_ADDR_TLOW 5'h10

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define UWT_CTRL_MODE 7
`define UWT_CTRL_UNUSED 6
`define UWT_CTRL_FILT 5
`define UWT_CTRL_REN 4
`define UWT_CTRL_TB9 3
`define UWT_CTRL_RB9 2
`define UWT_CTRL_TXD 1
`define UWT_CTRL_RXD 0
`define UWT_CFG_TEN 0
`define UWT_CFG_SEL_LO 1
`define UWT_CFG_SEL_HI 3
`define UWT_CFG_IEN 4

// ---------------------------------------------------------------------
// Clock selects, divisors and counts
// ---------------------------------------------------------------------
`define UWT_SEL_DIV4 3'h0
`define UWT_SEL_DIV12 3'h1
`define UWT_SEL_DIV48 3'h2
`define UWT_SEL_OSC8 3'h3
`define UWT_SEL_EXT 3'h4
`define UWT_DIV4 6'h04
`define UWT_DIV12 6'h0c
`define UWT_DIV48 6'h30
`define UWT_OSC_LAST 3'h7
`define UWT_BIT_LAST 3'h7
`define UWT_CNT_TOP 8'hff
`define UWT_RESET_BYTE 8'h00
`endif

// File: logic/uwt_pkg.sv
package uwt_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} uwt_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} uwt_rx_e;

	typedef struct packed {
		logic [7:0] count;
		logic phase;
	} uwt_cnt_s;

	typedef struct packed {
		logic [2:0] rx_sync;
		logic rx_line;
		logic [2:0] t1_sync;
		logic t1_line;
		logic [2:0] osc_sync;
		logic osc_line;
		logic [5:0] pre_cnt;
		logic [2:0] osc_cnt;
		logic frame_format_select;
		logic address_filter_enable;
		logic rx_enable_bit;
		logic ninth_tx_bit;
		logic ninth_rx_bit;
		logic tx_done_flag;
		logic rx_done_flag;
		logic tmr_en;
		logic [2:0] clk_sel;
		logic irq_en;
		logic [7:0] baud_reload_byte;
		logic [7:0] rx_buf;
		logic [7:0] rx_sr;
		logic rx_ninth;
		logic [2:0] rx_cnt;
		uwt_rx_e rxs;
		logic [7:0] tx_sr;
		logic [2:0] tx_cnt;
		logic tx_pend;
		uwt_tx_e txs;
		logic tx_line;
		logic irq;
		logic wreq;
		logic [31:0] rdata;
	} uwt_top_s;
endpackage

// File: logic/uwt_baud_counter.sv
`include "uwt_params.svh"
module uwt_baud_counter (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic tick,
	input wire logic [7:0] reload,
	input wire logic force_load,
	input wire logic [7:0] force_val,
	output logic [7:0] count,
	output logic ovf,
	output logic bit_tick
);
	uwt_pkg::uwt_cnt_s st;
	uwt_pkg::uwt_cnt_s next_st;

	assign count = st.count;
	assign ovf = run && tick && !force_load && (st.count == `UWT_CNT_TOP);
	// Every second overflow is a bit tick; phase zero first puts it mid-bit after a load.
	assign bit_tick = ovf && !st.phase;

	always_comb begin
		next_st = st;
		if (force_load) begin
			next_st.count = force_val;
			next_st.phase = 1'b0;
		end else if (run && tick) begin
			if (st.count == `UWT_CNT_TOP) begin
				next_st.count = reload;
				next_st.phase = !st.phase;
			end else begin
				next_st.count = st.count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// File: logic/uwt_top.sv
`include "uwt_params.svh"
module uwt_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_rx_pin,
	output logic serial_tx_pin,
	input wire logic timer_ext_input,
	input wire logic ext_osc_clk,
	output logic irq
);
	uwt_pkg::uwt_top_s st;
	uwt_pkg::uwt_top_s next_st;
	logic [7:0] tlow;
	logic tx_ovf;
	logic tx_tick;
	logic rx_ovf;
	logic rx_tick;
	logic [7:0] rx_count;
	logic tmr_tick;
	logic rx_force;
	logic tlow_wr;
	logic acc_wr;
	logic lane0;
	logic new_rx;
	logic new_t1;
	logic new_osc;
	logic rx_fall;
	logic [5:0] pre_lim;
	logic bit9;
	logic accept;

	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.wreq;
	assign serial_tx_pin = st.tx_line;
	assign irq = st.irq;

	// ---------------------------------------------------------------------
	// Pin filtering and timer clock selection
	// ---------------------------------------------------------------------
	// A change is only taken once the last two stages agree, which rejects one-cycle glitches.
	assign new_rx = (st.rx_sync[1] == st.rx_sync[2]) ? st.rx_sync[2] : st.rx_line;
	assign new_t1 = (st.t1_sync[1] == st.t1_sync[2]) ? st.t1_sync[2] : st.t1_line;
	assign new_osc = (st.osc_sync[1] == st.osc_sync[2]) ? st.osc_sync[2] : st.osc_line;
	assign rx_fall = st.rx_line && !new_rx;

	always_comb begin
		pre_lim = `UWT_DIV4;
		tmr_tick = 1'b0;
		case (st.clk_sel)
			`UWT_SEL_DIV4: begin
				pre_lim = `UWT_DIV4;
				tmr_tick = (st.pre_cnt >= pre_lim - 6'h01);
			end
			`UWT_SEL_DIV12: begin
				pre_lim = `UWT_DIV12;
				tmr_tick = (st.pre_cnt >= pre_lim - 6'h01);
			end
			`UWT_SEL_DIV48: begin
				pre_lim = `UWT_DIV48;
				tmr_tick = (st.pre_cnt >= pre_lim - 6'h01);
			end
			`UWT_SEL_OSC8: begin
				tmr_tick = new_osc && !st.osc_line && (st.osc_cnt == `UWT_OSC_LAST);
			end
			`UWT_SEL_EXT: begin
				// The timer pin counts on its falling edge.
				tmr_tick = st.t1_line && !new_t1;
			end
			default: begin
				tmr_tick = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------------
	// Baud counters
	// ---------------------------------------------------------------------
	assign lane0 = avs_byteenable[0];
	assign acc_wr = avs_write && !st.wreq && lane0;
	assign tlow_wr = acc_wr && (avs_address == `UWT_ADDR_TLOW);
	// The receive counter only restarts from an idle line so a frame keeps its phase.
	assign rx_force = (st.rxs == uwt_pkg::RX_IDLE) && st.rx_enable_bit && rx_fall;

	uwt_baud_counter u_tx_cnt (
		.clk(clk),
		.rstn(rstn),
		.run(st.tmr_en),
		.tick(tmr_tick),
		.reload(st.baud_reload_byte),
		.force_load(tlow_wr),
		.force_val(avs_writedata[7:0]),
		.count(tlow),
		.ovf(tx_ovf),
		.bit_tick(tx_tick)
	);

	uwt_baud_counter u_rx_cnt (
		.clk(clk),
		.rstn(rstn),
		.run(st.tmr_en),
		.tick(tmr_tick),
		.reload(st.baud_reload_byte),
		.force_load(rx_force),
		.force_val(st.baud_reload_byte),
		.count(rx_count),
		.ovf(rx_ovf),
		.bit_tick(rx_tick)
	);

	assign bit9 = st.frame_format_select ? st.rx_ninth : st.rx_line;
	assign accept = !st.rx_done_flag && (!st.address_filter_enable || bit9);

	// ---------------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rx_sync = {st.rx_sync[1:0], serial_rx_pin};
		next_st.t1_sync = {st.t1_sync[1:0], timer_ext_input};
		next_st.osc_sync = {st.osc_sync[1:0], ext_osc_clk};
		next_st.rx_line = new_rx;
		next_st.t1_line = new_t1;
		next_st.osc_line = new_osc;
		if (st.pre_cnt >= pre_lim - 6'h01) begin
			next_st.pre_cnt = 6'h00;
		end else begin
			next_st.pre_cnt = st.pre_cnt + 6'h01;
		end
		if (new_osc && !st.osc_line) begin
			next_st.osc_cnt = st.osc_cnt + 3'h1;
		end

		// Bus slave: one wait cycle, then the access completes.
		next_st.wreq = 1'b1;
		if ((avs_read || avs_write) && st.wreq) begin
			next_st.wreq = 1'b0;
			case (avs_address)
				`UWT_ADDR_CTRL: begin
					next_st.rdata = {24'h000000, st.frame_format_select, 1'b1,
						st.address_filter_enable, st.rx_enable_bit, st.ninth_tx_bit,
						st.ninth_rx_bit, st.tx_done_flag, st.rx_done_flag};
				end
				`UWT_ADDR_DATA: begin
					next_st.rdata = {24'h000000, st.rx_buf};
				end
				`UWT_ADDR_CFG: begin
					next_st.rdata = {27'h0000000, st.irq_en, st.clk_sel, st.tmr_en};
				end
				`UWT_ADDR_RELOAD: begin
					next_st.rdata = {24'h000000, st.baud_reload_byte};
				end
				`UWT_ADDR_TLOW: begin
					next_st.rdata = {24'h000000, tlow};
				end
				default: begin
					next_st.rdata = 32'h00000000;
				end
			endcase
		end
		if (acc_wr) begin
			case (avs_address)
				`UWT_ADDR_CTRL: begin
					next_st.frame_format_select = avs_writedata[`UWT_CTRL_MODE];
					next_st.address_filter_enable = avs_writedata[`UWT_CTRL_FILT];
					next_st.rx_enable_bit = avs_writedata[`UWT_CTRL_REN];
					next_st.ninth_tx_bit = avs_writedata[`UWT_CTRL_TB9];
					next_st.ninth_rx_bit = avs_writedata[`UWT_CTRL_RB9];
					next_st.tx_done_flag = avs_writedata[`UWT_CTRL_TXD];
					next_st.rx_done_flag = avs_writedata[`UWT_CTRL_RXD];
				end
				`UWT_ADDR_DATA: begin
					// A write while a frame is under way is dropped; the holder has one slot.
					if (st.txs == uwt_pkg::TX_IDLE && !st.tx_pend) begin
						next_st.tx_sr = avs_writedata[7:0];
						next_st.tx_pend = 1'b1;
					end
				end
				`UWT_ADDR_CFG: begin
					next_st.tmr_en = avs_writedata[`UWT_CFG_TEN];
					next_st.clk_sel = avs_writedata[`UWT_CFG_SEL_HI:`UWT_CFG_SEL_LO];
					next_st.irq_en = avs_writedata[`UWT_CFG_IEN];
				end
				`UWT_ADDR_RELOAD: begin
					next_st.baud_reload_byte = avs_writedata[7:0];
				end
				default: begin
				end
			endcase
		end

		// Transmitter: hardware sets below win over a clearing write above.
		case (st.txs)
			uwt_pkg::TX_IDLE: begin
				next_st.tx_line = 1'b1;
				if (tx_tick && st.tx_pend) begin
					next_st.txs = uwt_pkg::TX_START;
					next_st.tx_line = 1'b0;
					next_st.tx_pend = 1'b0;
				end
			end
			uwt_pkg::TX_START: begin
				if (tx_tick) begin
					next_st.txs = uwt_pkg::TX_DATA;
					next_st.tx_line = st.tx_sr[0];
					next_st.tx_cnt = 3'h0;
				end
			end
			uwt_pkg::TX_DATA: begin
				if (tx_tick) begin
					if (st.tx_cnt == `UWT_BIT_LAST) begin
						if (st.frame_format_select) begin
							next_st.txs = uwt_pkg::TX_NINTH;
							next_st.tx_line = st.ninth_tx_bit;
						end else begin
							next_st.txs = uwt_pkg::TX_STOP;
							next_st.tx_line = 1'b1;
							next_st.tx_done_flag = 1'b1;
						end
					end else begin
						next_st.tx_sr = {1'b0, st.tx_sr[7:1]};
						next_st.tx_line = st.tx_sr[1];
						next_st.tx_cnt = st.tx_cnt + 3'h1;
					end
				end
			end
			uwt_pkg::TX_NINTH: begin
				if (tx_tick) begin
					next_st.txs = uwt_pkg::TX_STOP;
					next_st.tx_line = 1'b1;
					next_st.tx_done_flag = 1'b1;
				end
			end
			uwt_pkg::TX_STOP: begin
				if (tx_tick) begin
					next_st.txs = uwt_pkg::TX_IDLE;
				end
			end
			default: begin
				next_st.txs = uwt_pkg::TX_IDLE;
				next_st.tx_line = 1'b1;
			end
		endcase

		// Receiver: the shifter is apart from the buffer so a new frame can start at once.
		case (st.rxs)
			uwt_pkg::RX_IDLE: begin
				if (rx_force) begin
					next_st.rxs = uwt_pkg::RX_START;
				end
			end
			uwt_pkg::RX_START: begin
				if (rx_tick) begin
					next_st.rxs = st.rx_line ? uwt_pkg::RX_IDLE : uwt_pkg::RX_DATA;
					next_st.rx_cnt = 3'h0;
				end
			end
			uwt_pkg::RX_DATA: begin
				if (rx_tick) begin
					next_st.rx_sr = {st.rx_line, st.rx_sr[7:1]};
					next_st.rx_cnt = st.rx_cnt + 3'h1;
					if (st.rx_cnt == `UWT_BIT_LAST) begin
						next_st.rxs = st.frame_format_select ? uwt_pkg::RX_NINTH : uwt_pkg::RX_STOP;
					end
				end
			end
			uwt_pkg::RX_NINTH: begin
				if (rx_tick) begin
					next_st.rx_ninth = st.rx_line;
					next_st.rxs = uwt_pkg::RX_STOP;
				end
			end
			uwt_pkg::RX_STOP: begin
				if (rx_tick) begin
					next_st.rxs = uwt_pkg::RX_IDLE;
					// A full buffer keeps the first byte and the new frame is dropped.
					if (accept) begin
						next_st.rx_buf = st.rx_sr;
						next_st.ninth_rx_bit = bit9;
						next_st.rx_done_flag = 1'b1;
					end
				end
			end
			default: begin
				next_st.rxs = uwt_pkg::RX_IDLE;
			end
		endcase

		next_st.irq = st.irq_en && (st.tx_done_flag || st.rx_done_flag);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.rx_sync <= 3'h7;
			st.rx_line <= 1'b1;
			st.t1_sync <= 3'h7;
			st.t1_line <= 1'b1;
			st.tx_line <= 1'b1;
			st.wreq <= 1'b1;
			st.txs <= uwt_pkg::TX_IDLE;
			st.rxs <= uwt_pkg::RX_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic ctrl_wr;
	logic data_rd;
	assign ctrl_wr = acc_wr && (avs_address == `UWT_ADDR_CTRL);
	assign data_rd = avs_read && !st.wreq && (avs_address == `UWT_ADDR_DATA);

	sequence s_tx_enter_stop;
		(st.txs != uwt_pkg::TX_STOP) ##1 (st.txs == uwt_pkg::TX_STOP);
	endsequence
	sequence s_rx_reject;
		(st.rxs == uwt_pkg::RX_STOP) && rx_tick && st.rx_done_flag && !ctrl_wr;
	endsequence

	AST_WR_TO_TX: assert property (
		acc_wr && avs_address == `UWT_ADDR_DATA && st.txs == uwt_pkg::TX_IDLE && !st.tx_pend
		|=> st.tx_pend && st.tx_sr == $past(avs_writedata[7:0]) && $stable(st.rx_buf))
		else $error("Data write did not reach the transmit holder.");
	AST_RD_RX: assert property (
		data_rd && $stable(st.rx_buf) |-> avs_readdata == {24'h000000, st.rx_buf})
		else $error("Data read did not return the receive buffer.");
	AST_FLAGS_STICK: assert property (
		(st.tx_done_flag || st.rx_done_flag) && !ctrl_wr
		|=> (st.tx_done_flag || !$past(st.tx_done_flag)) && (st.rx_done_flag || !$past(st.rx_done_flag)))
		else $error("Done flag cleared without software.");
	AST_IRQ: assert property (
		st.irq_en && (st.tx_done_flag || st.rx_done_flag) |=> irq)
		else $error("Interrupt missing for a set done flag.");
	AST_RX_FORCE: assert property (
		rx_force |=> rx_count == $past(st.baud_reload_byte) && st.rxs == uwt_pkg::RX_START)
		else $error("Start bit did not reload the receive counter.");
	AST_TXDONE_AT_STOP: assert property (
		s_tx_enter_stop |-> st.tx_done_flag && serial_tx_pin)
		else $error("Transmit done not set at stop bit start.");
	AST_RX_ENABLE: assert property (
		!st.rx_enable_bit && st.rxs == uwt_pkg::RX_IDLE |=> st.rxs == uwt_pkg::RX_IDLE)
		else $error("Receiver started while disabled.");
	AST_OVERRUN: assert property (
		s_rx_reject |=> $stable(st.rx_buf) && $stable(st.ninth_rx_bit))
		else $error("Overrun frame overwrote the buffer.");
	AST_LINE_LEVELS: assert property (
		(st.txs == uwt_pkg::TX_START |-> !serial_tx_pin) and
		(st.txs == uwt_pkg::TX_IDLE && !$past(st.txs == uwt_pkg::TX_STOP, 1) |-> serial_tx_pin))
		else $error("Transmit line level wrong for idle or start.");
endmodule

// File: test/uwt_remote.sv
module uwt_remote (
	input wire logic clk,
	input wire logic serial_tx_pin,
	output logic serial_rx_pin,
	input wire logic signed [31:0] bit_cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] got;
	int frames;
	int low_len;
	time t0;
	// ---------------------------------------------------------------
	// Receiver of the device's transmit line
	// ---------------------------------------------------------------
	initial begin
		serial_rx_pin = 1'b1;
		got = 10'h000;
		frames = 0;
		low_len = 0;
	end
	// Sampling at mid-bit keeps the model tolerant of the first tick's phase.
	always begin
		@(negedge serial_tx_pin);
		repeat (bit_cycles / 2) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			repeat (bit_cycles) @(posedge clk);
			got[i] = serial_tx_pin;
		end
		frames++;
	end
	always begin
		@(negedge serial_tx_pin);
		t0 = $time;
		@(posedge serial_tx_pin);
		low_len = int'(($time - t0) / 8);
	end
	// ---------------------------------------------------------------
	// Sender towards the device's receive line
	// ---------------------------------------------------------------
	task automatic send_frame(input logic [10:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			serial_rx_pin <= b[i];
			repeat (bit_cycles) @(posedge clk);
		end
		serial_rx_pin <= 1'b1;
	endtask
endmodule

// File: test/testbench.sv
`include "uwt_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rstn;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic serial_rx_pin;
	logic serial_tx_pin;
	logic irq;
	logic [7:0] rd;
	logic ext_clk;
	int ext_n;
	int bitc;
	int n_fail;
	int checks;
	uwt_top dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
		.timer_ext_input(ext_clk), .ext_osc_clk(ext_clk), .irq(irq));
	uwt_remote remote (.clk(clk), .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin),
		.bit_cycles(bitc));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// The slow outside clock toggles every five cycles, so each level passes the pin filter.
	always @(posedge clk) begin
		if (ext_n == 4) begin
			ext_n <= 0;
			ext_clk <= ~ext_clk;
		end else begin
			ext_n <= ext_n + 1;
		end
	end
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Called just after a rising edge; returns one edge after the answer, so no strobe
	// is assigned twice in one time step between two accesses.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			tally_and_finish();
		end
		@(posedge clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input string what, input logic [4:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(what, rd, exp);
	endtask
	// The transmitter stays busy to the end of its stop bit, so a bit time is added.
	task automatic wait_frames(input int f);
		int n;
		n = 0;
		while (remote.frames < f && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) begin
			n_fail++;
			tally_and_finish();
		end
		repeat (bitc) @(posedge clk);
	endtask
	task automatic rx_frame(input logic [10:0] b, input int n);
		remote.send_frame(b, n);
		repeat (4) @(posedge clk);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic sc_reset;
		check("tx idle", serial_tx_pin, 1'b1);
		check("irq idle", irq, 1'b0);
		rdchk("ctrl reset", `UWT_ADDR_CTRL, 8'h40);
		rdchk("data reset", `UWT_ADDR_DATA, 8'h00);
		rdchk("unmapped", 5'h14, 8'h00);
		wr(`UWT_ADDR_TLOW, 8'hfd);
		rdchk("timer low", `UWT_ADDR_TLOW, 8'hfd);
	endtask
	task automatic sc_tx8;
		int f;
		int n;
		wr(`UWT_ADDR_RELOAD, 8'hfe);
		wr(`UWT_ADDR_CFG, 8'h11);
		rdchk("reload", `UWT_ADDR_RELOAD, 8'hfe);
		rdchk("cfg", `UWT_ADDR_CFG, 8'h11);
		f = remote.frames;
		wr(`UWT_ADDR_DATA, 8'h55);
		n = 0;
		while (irq !== 1'b1 && n < 500) begin
			@(posedge clk);
			n++;
		end
		check("irq on done", irq, 1'b1);
		check("line at done", serial_tx_pin, 1'b1);
		check("done before stop end", 16'(remote.frames - f), 16'h0000);
		wait_frames(f + 1);
		check("tx8 bits", remote.got[8:0], 9'h155);
		rdchk("done held", `UWT_ADDR_CTRL, 8'h42);
		rdchk("data is rx", `UWT_ADDR_DATA, 8'h00);
		wr(`UWT_ADDR_CTRL, 8'h00);
		repeat (2) @(posedge clk);
		check("irq cleared", irq, 1'b0);
	endtask
	task automatic sc_clksel;
		// The outside clock has a period of ten cycles: eighty per oscillator tick.
		int divs[5] = '{4, 12, 48, 80, 10};
		int f;
		for (int s = 0; s < 5; s++) begin
			bitc = 2 * (256 - 254) * divs[s];
			wr(`UWT_ADDR_CFG, {3'h0, 1'b1, 3'(s), 1'b1});
			f = remote.frames;
			wr(`UWT_ADDR_DATA, 8'h55);
			wait_frames(f + 1);
			check("bit length", 16'(remote.low_len), 16'(bitc));
			check("tx bits", remote.got[8:0], 9'h155);
		end
		bitc = 16;
		wr(`UWT_ADDR_CFG, 8'h11);
	endtask
	task automatic sc_tx9;
		int f;
		wr(`UWT_ADDR_CTRL, 8'h88);
		f = remote.frames;
		wr(`UWT_ADDR_DATA, 8'h55);
		wait_frames(f + 1);
		check("tx9 ninth one", remote.got, 10'h355);
		wr(`UWT_ADDR_CTRL, 8'h80);
		f = remote.frames;
		wr(`UWT_ADDR_DATA, 8'haa);
		wait_frames(f + 1);
		check("tx9 ninth zero", remote.got, 10'h2aa);
	endtask
	task automatic sc_rx8;
		wr(`UWT_ADDR_CTRL, 8'h00);
		rx_frame({1'b1, 8'h3c, 1'b0}, 10);
		rdchk("rx disabled", `UWT_ADDR_CTRL, 8'h40);
		wr(`UWT_ADDR_CTRL, 8'h10);
		wr(`UWT_ADDR_DATA, 8'h55);
		repeat (5) @(posedge clk);
		rx_frame({1'b1, 8'h3c, 1'b0}, 10);
		bus(1'b0, `UWT_ADDR_CTRL, 8'h00);
		check("rx8 ctrl", rd & 8'hfd, 8'h55);
		rdchk("rx8 data", `UWT_ADDR_DATA, 8'h3c);
		rx_frame({1'b1, 8'h77, 1'b0}, 10);
		rdchk("overrun keeps first", `UWT_ADDR_DATA, 8'h3c);
		fork
			remote.send_frame({1'b1, 8'hc3, 1'b0}, 10);
		join_none
		repeat (bitc * 3) @(posedge clk);
		rdchk("held while shifting", `UWT_ADDR_DATA, 8'h3c);
		wr(`UWT_ADDR_CTRL, 8'h30);
		wait fork;
		repeat (4) @(posedge clk);
		rdchk("second byte", `UWT_ADDR_DATA, 8'hc3);
		rdchk("stop checked ok", `UWT_ADDR_CTRL, 8'h75);
		wr(`UWT_ADDR_CTRL, 8'h30);
		rx_frame({1'b0, 8'h99, 1'b0}, 10);
		rdchk("bad stop ctrl", `UWT_ADDR_CTRL, 8'h70);
		rdchk("bad stop data", `UWT_ADDR_DATA, 8'hc3);
	endtask
	task automatic sc_rx9;
		wr(`UWT_ADDR_CTRL, 8'hb0);
		rx_frame({2'b10, 8'h12, 1'b0}, 11);
		rdchk("filtered ctrl", `UWT_ADDR_CTRL, 8'hf0);
		rdchk("filtered data", `UWT_ADDR_DATA, 8'hc3);
		rx_frame({2'b11, 8'h5a, 1'b0}, 11);
		rdchk("address ctrl", `UWT_ADDR_CTRL, 8'hf5);
		rdchk("address data", `UWT_ADDR_DATA, 8'h5a);
		wr(`UWT_ADDR_CTRL, 8'h90);
		rx_frame({2'b10, 8'h21, 1'b0}, 11);
		rdchk("open ctrl", `UWT_ADDR_CTRL, 8'hd1);
		rdchk("open data", `UWT_ADDR_DATA, 8'h21);
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		ext_clk = 1'b0;
		ext_n = 0;
		bitc = 16;
		n_fail = 0;
		checks = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		sc_reset();
		sc_tx8();
		sc_clksel();
		sc_tx9();
		sc_rx8();
		sc_rx9();
		tally_and_finish();
	end
endmodule
